// [hdl/epc_cmd_decoder.sv]
`timescale 1ns/100ps
`include "epc_map.svh"
module epc_cmd_decoder
	import epc_pkg::*;
#(
	parameter int XBYTES = 25,
	parameter int ROWS = 200,
	parameter int COOL_CYC = `EPC_COOL_MS * 1000 * `EPC_MCLK_MHZ,
	parameter int OP_CYC = `EPC_OP_US * `EPC_MCLK_MHZ,
	parameter int SENSE_CYC = `EPC_SENSE_S * 1000000 * `EPC_MCLK_MHZ
) (
	input wire logic mclk, // core clock
	input wire logic rst, // async reset, also the hardware reset pulse
	input wire logic sclk, // serial link clock
	input wire logic cs_n, // chip select
	input wire logic dc, // high: data byte, low: command byte
	input wire logic sda_in, // serial data in
	output logic sda_out, // serial read data
	output logic sda_oe_n, // low while driving read data
	output logic busy, // high while an operation runs or asleep
	input wire logic [31:0] init_code, // stored initial code bytes
	input wire logic ram_read_plane, // 1 reads red plane
	input wire logic hv_ready_pin, // high voltage is ready
	input wire logic supply_low_pin, // supply below threshold
	input wire logic [7:0] sense_level_pin, // sensed electrode level
	output epc_boost_t boost, // soft start settings
	output logic [2:0][5:0] phase_ms, // phase durations in ms
	output logic [1:0] power_state, // sleep setting
	output logic [7:0] hv_cfg, // detection parameter
	output logic [2:0] supply_thr, // supply threshold code
	output logic [7:0] temp_src, // temperature source select
	output logic [11:0] temp_val, // temperature value
	output logic [23:0] sensor_cmd, // sensor command bytes
	output logic [2:0] sensor_bytes, // bytes to send to sensor
	output logic sensor_run, // sensor transfer in progress
	output epc_upopt_t update_opt, // plane options
	output epc_entry_t entry_mode, // data entry order
	output logic [7:0] seq_opt, // update stage select
	output logic update_run, // update sequence in progress
	output logic clock_stage_on, // clock stage enabled
	output logic analog_stage_on, // analog stage enabled
	output logic high_voltage_not_ready, // detection result
	output logic supply_level_low, // detection result
	output logic [7:0] common_electrode_level // stored sensed level
);
	localparam int DEPTH = XBYTES * ROWS;
	localparam int AW = $clog2(DEPTH);
	localparam logic [7:0] XLAST = 8'(XBYTES - 1);
	localparam logic [7:0] YLAST = 8'(ROWS - 1);

	function automatic epc_cfg_t cfg_default();
		epc_cfg_t c;
		c.boost = `EPC_R_BOOST;
		c.hv = `EPC_R_HV;
		c.thr = `EPC_R_THR;
		c.tsrc = `EPC_R_TSRC;
		c.temp = `EPC_R_TEMP;
		c.tcmd = `EPC_R_TCMD;
		c.upopt = `EPC_R_UPOPT;
		c.entry = `EPC_R_ENTRY;
		c.seq = `EPC_R_SEQ;
		return c;
	endfunction

	localparam epc_cfg_t CFG_DEF = cfg_default();

	function automatic logic [31:0] hv_len(input logic [7:0] b);
		logic [31:0] loops;
		loops = (b[`EPC_F_HVM] == 3'h0) ? 32'h1 : {29'h0, b[`EPC_F_HVM]};
		return 32'(COOL_CYC) * ({29'h0, b[`EPC_F_HVN]} + 32'h1) * loops;
	endfunction

	// returns {wrapped, next}
	function automatic logic [8:0] step1(input logic [7:0] v,
			input logic inc, input logic [7:0] last);
		if (inc) begin
			return (v == last) ? {1'b1, 8'h00} : {1'b0, v + 8'h01};
		end
		return (v == 8'h00) ? {1'b1, last} : {1'b0, v - 8'h01};
	endfunction

	// link side: bytes assembled on sclk, handed over by toggle
	logic [2:0] bit_cnt_q;
	logic [6:0] sh_q;
	logic [7:0] lbyte_q;
	logic ldc_q;
	logic tog_q;
	logic [6:0] osh_q;
	logic [7:0] rd_word_q;
	logic rd_active_q;

	always_ff @(posedge sclk or posedge rst or posedge cs_n) begin
		if (rst || cs_n) begin
			bit_cnt_q <= 3'h0;
			sh_q <= 7'h00;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			sh_q <= {sh_q[5:0], sda_in};
		end
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			lbyte_q <= 8'h00;
			ldc_q <= 1'b0;
			tog_q <= 1'b0;
		end else if (!cs_n && bit_cnt_q == 3'h7) begin
			lbyte_q <= {sh_q, sda_in};
			ldc_q <= dc;
			tog_q <= ~tog_q;
		end
	end

	// read word is changed by the core only between bytes
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			osh_q <= 7'h00;
		end else if (bit_cnt_q == 3'h1) begin
			osh_q <= rd_word_q[6:0];
		end else begin
			osh_q <= {osh_q[5:0], 1'b0};
		end
	end

	assign sda_out = (bit_cnt_q == 3'h0) ? rd_word_q[7] : osh_q[6];
	assign sda_oe_n = ~(rd_active_q && !cs_n && dc);

	// core side
	logic [2:0] tog_s_q;
	logic [1:0] hv_s_q;
	logic [1:0] sup_s_q;
	logic [7:0] lvl1_q;
	logic [7:0] lvl2_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tog_s_q <= 3'h0;
			hv_s_q <= 2'h0;
			sup_s_q <= 2'h0;
			lvl1_q <= 8'h00;
			lvl2_q <= 8'h00;
		end else begin
			tog_s_q <= {tog_s_q[1:0], tog_q};
			hv_s_q <= {hv_s_q[0], hv_ready_pin};
			sup_s_q <= {sup_s_q[0], supply_low_pin};
			lvl1_q <= sense_level_pin;
			lvl2_q <= lvl1_q;
		end
	end

	epc_state_t state_q;
	logic [31:0] cnt_q;
	logic [7:0] op_q;
	epc_cfg_t cfg_q;
	logic [7:0] cmd_q;
	logic [1:0] idx_q;
	logic [1:0] ridx_q;
	logic [7:0] x_q;
	logic [7:0] y_q;
	logic ev, cmd_ev, dat_ev, op_go, op_done, sleep_go;
	logic [31:0] op_len;
	logic [7:0] op_code;

	assign ev = tog_s_q[2] ^ tog_s_q[1];
	assign cmd_ev = ev && !ldc_q && state_q == EPC_IDLE;
	assign dat_ev = ev && ldc_q && state_q == EPC_IDLE;
	assign sleep_go = dat_ev && cmd_q == `EPC_C_SLEEP &&
		lbyte_q[1:0] != `EPC_R_SLEEP;

	always_comb begin
		op_go = 1'b0;
		op_len = 32'(OP_CYC);
		op_code = cmd_ev ? lbyte_q : cmd_q;
		if (cmd_ev) begin
			case (lbyte_q)
				`EPC_C_SWRST, `EPC_C_RUN: op_go = 1'b1;
				`EPC_C_SENSE: begin
					op_go = 1'b1;
					op_len = 32'(SENSE_CYC);
				end
				default: op_go = 1'b0;
			endcase
		end else if (dat_ev) begin
			case (cmd_q)
				`EPC_C_HVDET: begin
					op_go = 1'b1;
					op_len = hv_len(lbyte_q);
				end
				`EPC_C_SUPDET: op_go = (idx_q == 2'h0);
				`EPC_C_TCMD: op_go = (idx_q == 2'h2);
				default: op_go = 1'b0;
			endcase
		end
	end

	// detection finishes early once high voltage reports ready
	assign op_done = state_q == EPC_BUSY && (cnt_q == 32'h0 ||
		(op_q == `EPC_C_HVDET && hv_s_q[1]));

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= EPC_IDLE;
			cnt_q <= 32'h0;
			op_q <= 8'h00;
		end else begin
			case (state_q)
				EPC_IDLE: begin
					if (sleep_go) begin
						state_q <= EPC_SLEEP;
					end else if (op_go) begin
						state_q <= EPC_BUSY;
						cnt_q <= op_len - 32'h1;
						op_q <= op_code;
					end
				end
				EPC_BUSY: begin
					if (op_done) begin
						state_q <= EPC_IDLE;
					end else begin
						cnt_q <= cnt_q - 32'h1;
					end
				end
				EPC_SLEEP: state_q <= EPC_SLEEP;
				default: state_q <= EPC_IDLE;
			endcase
		end
	end

	assign busy = state_q != EPC_IDLE;
	assign update_run = state_q == EPC_BUSY && op_q == `EPC_C_RUN;
	assign sensor_run = state_q == EPC_BUSY && op_q == `EPC_C_TCMD;

	// configuration; sleep setting kept apart so soft reset spares it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_q <= CFG_DEF;
			cmd_q <= 8'h00;
			idx_q <= 2'h0;
		end else if (cmd_ev) begin
			cmd_q <= lbyte_q;
			idx_q <= 2'h0;
			if (lbyte_q == `EPC_C_SWRST) begin
				cfg_q <= CFG_DEF;
			end
		end else if (dat_ev) begin
			if (idx_q != 2'h3) begin
				idx_q <= idx_q + 2'h1;
			end
			case (cmd_q)
				`EPC_C_BOOST: cfg_q.boost[idx_q] <= lbyte_q;
				`EPC_C_HVDET: cfg_q.hv <= lbyte_q;
				`EPC_C_SUPDET: cfg_q.thr <= lbyte_q[2:0];
				`EPC_C_TSRC: cfg_q.tsrc <= lbyte_q;
				`EPC_C_TWR: begin
					if (idx_q == 2'h0) begin
						cfg_q.temp[11:4] <= lbyte_q;
					end else if (idx_q == 2'h1) begin
						cfg_q.temp[3:0] <= lbyte_q[7:4];
					end
				end
				`EPC_C_TCMD: begin
					case (idx_q)
						2'h0: cfg_q.tcmd[23:16] <= lbyte_q;
						2'h1: cfg_q.tcmd[15:8] <= lbyte_q;
						2'h2: cfg_q.tcmd[7:0] <= lbyte_q;
						default: cfg_q.tcmd <= cfg_q.tcmd;
					endcase
				end
				`EPC_C_UPOPT: cfg_q.upopt <= lbyte_q;
				`EPC_C_ENTRY: cfg_q.entry <= lbyte_q[2:0];
				`EPC_C_SEQ: cfg_q.seq <= lbyte_q;
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			power_state <= `EPC_R_SLEEP;
		end else if (dat_ev && cmd_q == `EPC_C_SLEEP) begin
			power_state <= lbyte_q[1:0];
		end
	end

	// results and stage flags survive soft reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			high_voltage_not_ready <= 1'b0;
			supply_level_low <= 1'b0;
			common_electrode_level <= 8'h00;
			clock_stage_on <= 1'b0;
			analog_stage_on <= 1'b0;
		end else if (state_q == EPC_IDLE && op_go &&
				op_code == `EPC_C_RUN) begin
			clock_stage_on <= clock_stage_on |
				cfg_q.seq[`EPC_B_CLK_ON];
			analog_stage_on <= analog_stage_on |
				cfg_q.seq[`EPC_B_ANA_ON];
		end else if (op_done) begin
			case (op_q)
				`EPC_C_HVDET: high_voltage_not_ready <= ~hv_s_q[1];
				`EPC_C_SUPDET: supply_level_low <= sup_s_q[1];
				`EPC_C_SENSE: common_electrode_level <= lvl2_q;
				`EPC_C_RUN: begin
					clock_stage_on <= clock_stage_on &
						~cfg_q.seq[`EPC_B_CLK_OFF];
					analog_stage_on <= analog_stage_on &
						~cfg_q.seq[`EPC_B_ANA_OFF];
				end
				default: supply_level_low <= supply_level_low;
			endcase
		end
	end

	// display memory and address counter
	logic [7:0] mono_mem [DEPTH];
	logic [7:0] red_mem [DEPTH];
	logic [AW-1:0] addr;
	logic [8:0] sx, sy;
	logic wr_mono, wr_red, acc;
	epc_entry_t ent;

	assign ent = cfg_q.entry;
	assign addr = AW'(32'(y_q) * 32'(XBYTES) + 32'(x_q));
	assign sx = step1(x_q, ent.step_direction[0], XLAST);
	assign sy = step1(y_q, ent.step_direction[1], YLAST);
	assign wr_mono = dat_ev && cmd_q == `EPC_C_WMONO;
	assign wr_red = dat_ev && cmd_q == `EPC_C_WRED;
	assign acc = wr_mono || wr_red || (dat_ev && cmd_q == `EPC_C_RDRAM);

	always_ff @(posedge mclk) begin
		if (wr_mono) begin
			mono_mem[addr] <= lbyte_q;
		end
		if (wr_red) begin
			red_mem[addr] <= lbyte_q;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			x_q <= 8'h00;
			y_q <= 8'h00;
		end else if (acc) begin
			if (!ent.step_axis) begin
				x_q <= sx[7:0];
				if (sx[8]) begin
					y_q <= sy[7:0];
				end
			end else begin
				y_q <= sy[7:0];
				if (sy[8]) begin
					x_q <= sx[7:0];
				end
			end
		end
	end

	// read data for the next byte the host clocks out
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_word_q <= 8'h00;
			rd_active_q <= 1'b0;
			ridx_q <= 2'h0;
		end else if (cmd_ev) begin
			ridx_q <= 2'h0;
			rd_active_q <= lbyte_q == `EPC_C_INITRD ||
				lbyte_q == `EPC_C_TRD || lbyte_q == `EPC_C_RDRAM;
			case (lbyte_q)
				`EPC_C_INITRD: rd_word_q <= init_code[31:24];
				`EPC_C_TRD: rd_word_q <= cfg_q.temp[11:4];
				default: rd_word_q <= 8'h00;
			endcase
		end else if (dat_ev && rd_active_q) begin
			ridx_q <= ridx_q + 2'h1;
			case (cmd_q)
				`EPC_C_INITRD: begin
					case (ridx_q)
						2'h0: rd_word_q <= init_code[23:16];
						2'h1: rd_word_q <= init_code[15:8];
						2'h2: rd_word_q <= init_code[7:0];
						default: rd_word_q <= 8'h00;
					endcase
				end
				`EPC_C_TRD: begin
					rd_word_q <= (ridx_q == 2'h0) ?
						{cfg_q.temp[3:0], 4'h0} : 8'h00;
				end
				default: begin
					rd_word_q <= ram_read_plane ? red_mem[addr] :
						mono_mem[addr];
				end
			endcase
		end
	end

	// outputs unpacked from configuration
	always_comb begin
		boost = '0;
		phase_ms = '0;
		for (int g = 0; g < 3; g++) begin
			boost.phase[g].drive = cfg_q.boost[g][`EPC_F_DRV];
			boost.phase[g].off_time = cfg_q.boost[g][`EPC_F_OFF];
			boost.dur[g] = cfg_q.boost[3][2*g +: 2];
			phase_ms[g] = ({4'h0, cfg_q.boost[3][2*g +: 2]} + 6'h01) *
				6'(`EPC_DUR_STEP_MS);
		end
	end

	always_comb begin
		case (cfg_q.tcmd[23:22])
			2'h0: sensor_bytes = 3'h2;
			2'h1: sensor_bytes = 3'h3;
			2'h2: sensor_bytes = 3'h4;
			default: sensor_bytes = 3'h1;
		endcase
	end

	assign hv_cfg = cfg_q.hv;
	assign supply_thr = cfg_q.thr;
	assign temp_src = cfg_q.tsrc;
	assign temp_val = cfg_q.temp;
	assign sensor_cmd = cfg_q.tcmd;
	assign update_opt = cfg_q.upopt;
	assign entry_mode = cfg_q.entry;
	assign seq_opt = cfg_q.seq;
endmodule

// [hdl/epc_map.svh]
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH
// command codes
`define EPC_C_INITRD 8'h0a
`define EPC_C_BOOST 8'h0c
`define EPC_C_SLEEP 8'h10
`define EPC_C_ENTRY 8'h11
`define EPC_C_SWRST 8'h12
`define EPC_C_HVDET 8'h14
`define EPC_C_SUPDET 8'h15
`define EPC_C_TSRC 8'h18
`define EPC_C_TWR 8'h1a
`define EPC_C_TRD 8'h1b
`define EPC_C_TCMD 8'h1c
`define EPC_C_RUN 8'h20
`define EPC_C_UPOPT 8'h21
`define EPC_C_SEQ 8'h22
`define EPC_C_WMONO 8'h24
`define EPC_C_WRED 8'h26
`define EPC_C_RDRAM 8'h27
`define EPC_C_SENSE 8'h28
// reset values
`define EPC_R_BOOST {8'h0f, 8'h96, 8'h9c, 8'h8b}
`define EPC_R_HV 8'h00
`define EPC_R_THR 3'h4
`define EPC_R_TSRC 8'h48
`define EPC_R_TEMP 12'h7ff
`define EPC_R_TCMD 24'h000000
`define EPC_R_UPOPT 8'h00
`define EPC_R_ENTRY 3'h3
`define EPC_R_SEQ 8'hff
`define EPC_R_SLEEP 2'h0
// field positions
`define EPC_F_DRV 6:4
`define EPC_F_OFF 3:0
`define EPC_F_HVN 6:4
`define EPC_F_HVM 2:0
`define EPC_F_TSEL 7:6
`define EPC_B_CLK_ON 7
`define EPC_B_ANA_ON 6
`define EPC_B_ANA_OFF 1
`define EPC_B_CLK_OFF 0
// timing
`define EPC_MCLK_MHZ 50
`define EPC_COOL_MS 10
`define EPC_DUR_STEP_MS 10
`define EPC_OP_US 100
`define EPC_SENSE_S 10
`endif

// [hdl/epc_pkg.sv]
package epc_pkg;
	typedef enum logic [2:0] {
		EPC_IDLE = 3'b001,
		EPC_BUSY = 3'b010,
		EPC_SLEEP = 3'b100
	} epc_state_t;
	typedef struct packed {
		logic [2:0] drive;
		logic [3:0] off_time;
	} epc_phase_t;
	typedef struct packed {
		epc_phase_t [2:0] phase;
		logic [2:0][1:0] dur;
	} epc_boost_t;
	typedef struct packed {
		logic [3:0] red;
		logic [3:0] mono;
	} epc_upopt_t;
	typedef struct packed {
		logic step_axis;
		logic [1:0] step_direction;
	} epc_entry_t;
	typedef struct packed {
		logic [3:0][7:0] boost;
		logic [7:0] hv;
		logic [2:0] thr;
		logic [7:0] tsrc;
		logic [11:0] temp;
		logic [23:0] tcmd;
		logic [7:0] upopt;
		logic [2:0] entry;
		logic [7:0] seq;
	} epc_cfg_t;
endpackage

// [testbench/epc_dec_chk_asserts.sv]
`timescale 1ns/100ps
module epc_dec_chk
	import epc_pkg::*;
#(
	parameter int OP_CYC = 5000
) (
	input wire logic mclk, // core clock
	input wire logic rst, // async reset
	input wire logic cs_n, // chip select
	input wire logic dc, // command or data
	input wire logic sda_oe_n, // read drive enable
	input wire logic busy, // operation running
	input wire logic [1:0] power_state, // sleep setting
	input wire logic [23:0] sensor_cmd, // sensor bytes
	input wire logic [2:0] sensor_bytes, // sensor byte count
	input wire logic sensor_run, // sensor transfer
	input wire logic update_run, // update sequence
	input wire epc_boost_t boost, // soft start settings
	input wire logic [2:0][5:0] phase_ms, // phase durations
	input wire logic [11:0] temp_val // temperature value
);
	logic [15:0] run_cnt_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// counts update cycles so the run length is checked without unrolling
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			run_cnt_q <= 16'h0;
		end else if (update_run) begin
			run_cnt_q <= run_cnt_q + 16'h1;
		end else begin
			run_cnt_q <= 16'h0;
		end
	end
	sequence s_sensor_start;
		$rose(sensor_run);
	endsequence
	sequence s_sensor_hold;
		(busy && sensor_run)[*4];
	endsequence
	property p_rst_idle;
		$fell(rst) |-> !busy && sda_oe_n;
	endproperty
	property p_oe_cs;
		cs_n |-> sda_oe_n;
	endproperty
	property p_oe_dc;
		!sda_oe_n |-> dc;
	endproperty
	property p_sleep;
		power_state != 2'h0 |=> busy;
	endproperty
	property p_sensor;
		s_sensor_start |-> s_sensor_hold;
	endproperty
	property p_update_busy;
		update_run |-> busy;
	endproperty
	property p_run_len;
		$fell(update_run) |-> run_cnt_q >= 16'(OP_CYC - 1)
			&& run_cnt_q <= 16'(OP_CYC + 2);
	endproperty
	property p_bytes;
		sensor_bytes == (sensor_cmd[23:22] == 2'h3 ? 3'h1
			: {1'b0, sensor_cmd[23:22]} + 3'h2);
	endproperty
	property p_phase;
		phase_ms[0] == 6'h0a * (6'(boost.dur[0]) + 6'h01)
			&& phase_ms[1] == 6'h0a * (6'(boost.dur[1]) + 6'h01)
			&& phase_ms[2] == 6'h0a * (6'(boost.dur[2]) + 6'h01);
	endproperty
	property p_temp_hold;
		busy |=> $stable(temp_val);
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("busy or read drive left on after reset");
	a_oe_cs: assert property (p_oe_cs)
		else $error("read data driven while deselected");
	a_oe_dc: assert property (p_oe_dc)
		else $error("read data driven during a command byte");
	a_sleep: assert property (p_sleep)
		else $error("busy low while asleep");
	a_sensor: assert property (p_sensor)
		else $error("sensor transfer without busy");
	a_update_busy: assert property (p_update_busy)
		else $error("update running without busy");
	a_run_len: assert property (p_run_len)
		else $error("update run length wrong");
	a_bytes: assert property (p_bytes)
		else $error("sensor byte count wrong");
	a_phase: assert property (p_phase)
		else $error("phase duration wrong");
	a_temp_hold: assert property (p_temp_hold)
		else $error("temperature changed while busy");
endmodule
bind epc_cmd_decoder epc_dec_chk #(.OP_CYC(OP_CYC)) u_chk (
	.mclk(mclk), .rst(rst), .cs_n(cs_n), .dc(dc), .sda_oe_n(sda_oe_n),
	.busy(busy), .power_state(power_state), .sensor_cmd(sensor_cmd),
	.sensor_bytes(sensor_bytes), .sensor_run(sensor_run),
	.update_run(update_run), .boost(boost), .phase_ms(phase_ms),
	.temp_val(temp_val)
);

// [testbench/epc_host.sv]
`timescale 1ns/100ps
module epc_host (
	output logic sclk, // link clock, still between bytes
	output logic cs_n, // select
	output logic dc, // low command, high data
	output logic sda_in, // data to device
	input wire logic sda_out, // read data
	input wire logic sda_oe_n // low while device drives
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		dc = 1'b1;
		sda_in = 1'b0;
	end
	// one byte, msb first; the long gap lets the core take it first
	task automatic xfer(input logic d_c, input logic [7:0] tx,
		output logic [7:0] rx);
		cs_n = 1'b0;
		dc = d_c;
		#16;
		for (int i = 7; i >= 0; i--) begin
			sda_in = tx[i];
			#16 sclk = 1'b1;
			rx[i] = sda_oe_n ? 1'bx : sda_out;
			#16 sclk = 1'b0;
		end
		#16 cs_n = 1'b1;
		sda_in = ~sda_in;
		#250;
	endtask
endmodule

// [testbench/tb_epaper_ctrl_command_decoder.sv]
`timescale 1ns/100ps
module tb_epaper_ctrl_command_decoder
	import epc_pkg::*;
;
	logic mclk = 1'b0, rst = 1'b1, ram_read_plane = 1'b0;
	logic hv_ready_pin = 1'b0, supply_low_pin = 1'b0;
	logic [31:0] init_code = 32'h0;
	logic [7:0] sense_level_pin = 8'h0;
	logic sclk, cs_n, dc, sda_in, sda_out, sda_oe_n, busy;
	logic sensor_run, update_run, clock_stage_on, analog_stage_on;
	logic high_voltage_not_ready, supply_level_low;
	epc_boost_t boost;
	logic [2:0][5:0] phase_ms;
	logic [1:0] power_state;
	logic [7:0] hv_cfg, temp_src, seq_opt, common_electrode_level;
	logic [2:0] supply_thr, sensor_bytes;
	logic [11:0] temp_val;
	logic [23:0] sensor_cmd;
	epc_upopt_t update_opt;
	epc_entry_t entry_mode;
	int err_total = 0, cmp_count = 0, busy_cyc = 0;
	epc_cmd_decoder #(.OP_CYC(8), .COOL_CYC(4), .SENSE_CYC(16)) dut (
		.mclk, .rst, .sclk, .cs_n, .dc, .sda_in, .sda_out, .sda_oe_n, .busy,
		.init_code, .ram_read_plane, .hv_ready_pin, .supply_low_pin,
		.sense_level_pin, .boost, .phase_ms, .power_state, .hv_cfg,
		.supply_thr, .temp_src, .temp_val, .sensor_cmd, .sensor_bytes,
		.sensor_run, .update_opt, .entry_mode, .seq_opt, .update_run,
		.clock_stage_on, .analog_stage_on, .high_voltage_not_ready,
		.supply_level_low, .common_electrode_level);
	epc_host host (.sclk, .cs_n, .dc, .sda_in, .sda_out, .sda_oe_n);
	always #10 mclk = ~mclk;
	always @(posedge mclk) if (busy === 1'b1) busy_cyc++;
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s %h vs %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		chk(32'(got >= lo && got <= hi), 32'h1, "cycles");
	endtask
	function automatic epc_boost_t mk_boost(input logic [31:0] v);
		epc_boost_t b;
		b.phase[0] = v[6:0];
		b.phase[1] = v[14:8];
		b.phase[2] = v[22:16];
		b.dur = v[29:24];
		return b;
	endfunction
	task automatic cmd(input logic [7:0] c);
		logic [7:0] r;
		host.xfer(1'b0, c, r);
	endtask
	task automatic par(input logic [7:0] d);
		logic [7:0] r;
		host.xfer(1'b1, d, r);
	endtask
	task automatic rd(output logic [7:0] r);
		host.xfer(1'b1, 8'hff, r);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		chk(32'(n < 5000), 32'h1, "idle");
	endtask
	// command with np parameter bytes taken lsb first, then wait for idle
	task automatic go(input logic [7:0] c, input logic [31:0] p, input int np);
		@(negedge mclk) busy_cyc = 0;
		cmd(c);
		for (int i = 0; i < np; i++) par(p[8*i +: 8]);
		wait_idle;
	endtask
	task automatic hreset;
		@(negedge mclk) rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	task automatic chk_def;
		chk(32'(boost), 32'(mk_boost(32'h0f969c8b)), "boost");
		chk(32'(hv_cfg), 32'h0, "hv");
		chk(32'(supply_thr), 32'h4, "thr");
		chk(32'(temp_src), 32'h48, "tsrc");
		chk(32'(temp_val), 32'h7ff, "temp");
		chk(32'(sensor_cmd), 32'h0, "tcmd");
		chk(32'(update_opt), 32'h0, "upopt");
		chk(32'(entry_mode), 32'h3, "entry");
		chk(32'(seq_opt), 32'hff, "seq");
	endtask
	initial begin
		#1000000;
		err_total++;
		$display("mismatch at %0t: watchdog", $time);
		end_of_test;
	end
	initial begin
		logic [7:0] r, a, b, c;
		logic [31:0] v;
		logic [7:0] seqs [12] = '{8'h80, 8'h01, 8'hc0, 8'h03, 8'h91, 8'h99,
			8'hb1, 8'hb9, 8'hc7, 8'hcf, 8'hf7, 8'hff};
		logic [7:0] thrs [4] = '{8'h03, 8'h04, 8'h05, 8'h07};
		v = $urandom(96077);
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		chk_def;
		chk(32'(power_state), 32'h0, "sleep");
		// each plane write lands at address zero after a hardware reset
		a = 8'($urandom);
		b = 8'($urandom);
		cmd(8'h24);
		par(a);
		hreset;
		cmd(8'h26);
		par(b);
		for (int p = 0; p < 2; p++) begin
			hreset;
			@(negedge mclk) ram_read_plane = p[0];
			cmd(8'h27);
			rd(r);
			rd(r);
			chk(32'(r), p ? 32'(b) : 32'(a), "ram");
		end
		// a row step on the second write leaves x=1 holding the first pass
		c = 8'($urandom);
		for (int e = 0; e < 2; e++) begin
			hreset;
			go(8'h11, e ? 32'h7 : 32'h3, 1);
			cmd(8'h24);
			par(e ? c : a);
			par(e ? ~b : b);
		end
		hreset;
		@(negedge mclk) ram_read_plane = 1'b0;
		cmd(8'h27);
		rd(r);
		rd(r);
		chk(32'(r), 32'(c), "ram");
		rd(r);
		chk(32'(r), 32'(b), "step");
		@(negedge mclk) init_code = $urandom;
		cmd(8'h0a);
		for (int i = 3; i >= 0; i--) begin
			rd(r);
			chk(32'(r), 32'(init_code[8*i +: 8]), "init");
		end
		for (int k = 0; k < 3; k++) begin
			v = k == 0 ? 32'h00848484 : k == 1 ? 32'h3fffffff : $urandom;
			v = (v & 32'h3f7f7f7f) | 32'h00808080;
			go(8'h0c, v, 4);
			chk(32'(boost), 32'(mk_boost(v)), "boost");
			for (int i = 0; i < 3; i++)
				chk(32'(phase_ms[i]), (32'(v[24+2*i +: 2]) + 32'h1) * 32'ha,
					"ms");
		end
		go(8'h18, 32'h80, 1);
		chk(32'(temp_src), 32'h80, "tsrc");
		v = $urandom & 32'hfff;
		go(8'h1a, {16'h0, v[3:0], 4'h0, v[11:4]}, 2);
		chk(32'(temp_val), v, "temp");
		cmd(8'h1b);
		rd(r);
		chk(32'(r), 32'(v[11:4]), "trd");
		rd(r);
		chk(32'(r), 32'({v[3:0], 4'h0}), "trd");
		for (int i = 0; i < 9; i++) begin
			a = {4'(i / 3 * 4), 4'(i % 3 * 4)};
			go(8'h21, 32'(a), 1);
			chk(32'(update_opt), 32'(a), "upopt");
		end
		for (int i = 0; i < 8; i++) begin
			if (i % 4 != 2) begin
				go(8'h11, 32'(i), 1);
				chk(32'(entry_mode), 32'(i), "entry");
			end
		end
		foreach (seqs[i]) begin
			go(8'h22, 32'(seqs[i]), 1);
			chk(32'(seq_opt), 32'(seqs[i]), "seq");
		end
		go(8'h22, 32'hc0, 1);
		go(8'h20, 32'h0, 0);
		chk_rng(busy_cyc, 8, 10);
		chk(32'({clock_stage_on, analog_stage_on}), 32'h3, "stage");
		// high voltage not ready, so detection runs its full length; a sleep request mid-run drops
		@(negedge mclk) busy_cyc = 0;
		cmd(8'h14);
		par(8'h77);
		cmd(8'h10);
		par(8'h01);
		wait_idle;
		chk_rng(busy_cyc, 222, 228);
		chk(32'(power_state), 32'h0, "drop");
		chk(32'(high_voltage_not_ready), 32'h1, "hv");
		@(negedge mclk) hv_ready_pin = 1'b1;
		go(8'h14, 32'h77, 1);
		chk_rng(busy_cyc, 1, 50);
		chk(32'(high_voltage_not_ready), 32'h0, "hv");
		chk(32'(hv_cfg), 32'h77, "hvcfg");
		foreach (thrs[i]) begin
			@(negedge mclk) supply_low_pin = 1'($urandom);
			go(8'h15, 32'(thrs[i]), 1);
			chk_rng(busy_cyc, 8, 10);
			chk(32'(supply_thr), 32'(thrs[i]), "thr");
			chk(32'(supply_level_low), 32'(supply_low_pin), "vlow");
		end
		for (int k = 0; k < 4; k++) begin
			v = $urandom;
			v[7:6] = k[1:0];
			go(8'h1c, v, 3);
			chk(32'(sensor_cmd), 32'({v[7:0], v[15:8], v[23:16]}), "tcmd");
			chk(32'(sensor_bytes), k == 3 ? 32'h1 : 32'(k + 2), "n");
		end
		@(negedge mclk) sense_level_pin = 8'($urandom);
		go(8'h28, 32'h0, 0);
		chk_rng(busy_cyc, 16, 18);
		chk(32'(common_electrode_level), 32'(sense_level_pin), "lvl");
		// stages are switched off at the end of an update run
		go(8'h22, 32'h03, 1);
		go(8'h20, 32'h0, 0);
		chk(32'({clock_stage_on, analog_stage_on}), 32'h0, "stage");
		go(8'h12, 32'h0, 0);
		chk_rng(busy_cyc, 8, 10);
		chk_def;
		cmd(8'h10);
		par(8'h01);
		repeat (100) @(negedge mclk);
		chk(32'(busy), 32'h1, "sleep");
		// asleep: busy never drops, so no wait for idle here
		cmd(8'h1a);
		par(8'h00);
		par(8'h00);
		chk(32'(temp_val), 32'h7ff, "temp");
		hreset;
		chk(32'({busy, power_state}), 32'h0, "wake");
		end_of_test;
	end
endmodule
